// ---- core/pit_pkg.sv ----
// Package with command-byte layout, port addresses and field codes of the interval timer access logic.
package pit_pkg;
   localparam logic [1:0] PIT_ADDR_UNIT0   = 2'h0;
   localparam logic [1:0] PIT_ADDR_UNIT1   = 2'h1;
   localparam logic [1:0] PIT_ADDR_UNIT2   = 2'h2;
   localparam logic [1:0] PIT_ADDR_CMD     = 2'h3;
   localparam int         PIT_UNITS        = 3;
   localparam int         PIT_PICK_HI_POS  = 7;
   localparam int         PIT_PICK_LO_POS  = 6;
   localparam int         PIT_FMT_HI_POS   = 5;
   localparam int         PIT_FMT_LO_POS   = 4;
   localparam int         PIT_OP_HI_POS    = 3;
   localparam int         PIT_OP_LO_POS    = 1;
   localparam int         PIT_BCD_POS      = 0;
   localparam int         PIT_RB_COUNT_POS = 5;
   localparam int         PIT_RB_STAT_POS  = 4;
   localparam int         PIT_STAT_OUT_POS = 7;
   localparam int         PIT_STAT_NULL_POS = 6;
   localparam logic [1:0] PIT_PICK_READBACK = 2'h3;
   localparam logic [1:0] PIT_FMT_LATCH    = 2'h0;
   localparam logic [1:0] PIT_FMT_LOW      = 2'h1;
   localparam logic [1:0] PIT_FMT_HIGH     = 2'h2;
   localparam logic [1:0] PIT_FMT_BOTH     = 2'h3;
   localparam logic [5:0] PIT_MODE_RESET   = 6'h10;
   localparam logic [7:0] PIT_BYTE_ZERO    = 8'h00;
   localparam logic [15:0] PIT_COUNT_ZERO  = 16'h0000;
endpackage

// ---- core/pit_unit.sv ----
// One counter's byte sequencing, holding register, snapshot latch and status latch.
module pit_unit
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // Decoded host strokes
   input  wire logic                 prog_stb,
   input  wire logic [5:0]           prog_word,
   input  wire logic                 cnt_latch_stb,
   input  wire logic                 stat_latch_stb,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   input  wire logic [7:0]           wr_data,
   // Counting element side
   input  wire logic [15:0]          ce_count,
   input  wire logic                 ce_out,
   input  wire logic                 ce_loaded,
   // Results
   output logic [7:0]                rd_byte,
   output logic [5:0]                mode_word,
   output logic [15:0]               preset_holding_reg,
   output logic                      preset_load,
   output logic                      null_count,
   output logic                      snap_held
);
   import pit_pkg::*;

   logic [1:0]  fmt;
   logic        wr_hi_q;
   logic        rd_hi_q;
   logic [15:0] read_snapshot_latch;
   logic        stat_held_q;
   logic [7:0]  stat_q;
   logic [5:0]  mode_q;
   logic [15:0] preset_q;
   logic        load_q;
   logic        null_q;
   logic        snap_q;
   logic        hi_stage;

   assign fmt                = mode_q[5:4];
   assign mode_word          = mode_q;
   assign preset_holding_reg = preset_q;
   assign preset_load        = load_q;
   assign null_count         = null_q;
   assign snap_held          = snap_q;
   // The second byte of a two-byte count is written into the high stage only when the pointer says so.
   assign hi_stage           = (fmt == PIT_FMT_HIGH) || (fmt == PIT_FMT_BOTH && wr_hi_q);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         mode_q <= PIT_MODE_RESET; // RULE1
      else if (prog_stb)
         mode_q <= prog_word;
   end

   // Write pointer, holding register and load pulse.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_hi_q  <= 1'b0;
         preset_q <= PIT_COUNT_ZERO;
         load_q   <= 1'b0;
      end
      else
      begin
         load_q <= 1'b0;
         if (prog_stb)
            wr_hi_q <= 1'b0; // RULE27
         else if (wr_stb)
         begin
            if (hi_stage)
               preset_q[15:8] <= wr_data; // RULE8
            else
               preset_q[7:0] <= wr_data; // RULE8
            if (fmt == PIT_FMT_LOW)
               preset_q[15:8] <= PIT_BYTE_ZERO; // RULE24
            if (fmt == PIT_FMT_HIGH)
               preset_q[7:0] <= PIT_BYTE_ZERO; // RULE24
            if (fmt == PIT_FMT_BOTH)
               wr_hi_q <= !wr_hi_q; // RULE17
            load_q <= (fmt != PIT_FMT_BOTH) || wr_hi_q; // RULE24
         end
      end
   end

   // Null count rises on programming or a completed count write and falls when the element loads.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         null_q <= 1'b1;
      else if (prog_stb || load_q)
         null_q <= 1'b1;
      else if (ce_loaded)
         null_q <= 1'b0;
   end

   // Count snapshot: the first latch wins until fully read or reprogrammed.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         snap_q              <= 1'b0;
         read_snapshot_latch <= PIT_COUNT_ZERO;
      end
      else if (prog_stb)
         snap_q <= 1'b0; // RULE14
      else if (cnt_latch_stb && !snap_q)
      begin
         snap_q              <= 1'b1; // RULE15
         read_snapshot_latch <= ce_count; // RULE14
      end
      else if (rd_stb && !stat_held_q && (fmt != PIT_FMT_BOTH || rd_hi_q))
         snap_q <= 1'b0; // RULE14
   end

   // Status snapshot, first latch wins.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stat_held_q <= 1'b0;
         stat_q      <= PIT_BYTE_ZERO;
      end
      else if (stat_latch_stb && !stat_held_q)
      begin
         stat_held_q <= 1'b1;
         stat_q      <= {ce_out, null_q, mode_q}; // RULE25
      end
      else if (rd_stb && stat_held_q)
         stat_held_q <= 1'b0; // RULE26
   end

   // Read pointer, separate from the write pointer.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         rd_hi_q <= 1'b0;
      else if (prog_stb)
         rd_hi_q <= 1'b0; // RULE27
      else if (rd_stb && !stat_held_q && fmt == PIT_FMT_BOTH)
         rd_hi_q <= !rd_hi_q; // RULE17
   end

   always_comb
   begin
      logic [15:0] src;
      src = snap_q ? read_snapshot_latch : ce_count;
      if (stat_held_q)
         rd_byte = stat_q; // RULE26
      else if (fmt == PIT_FMT_HIGH || (fmt == PIT_FMT_BOTH && rd_hi_q))
         rd_byte = src[15:8]; // RULE16
      else
         rd_byte = src[7:0]; // RULE16
   end

   property p_first_latch_wins;
      @(posedge clk_sys) disable iff (!rst_b)
      snap_q && cnt_latch_stb && !prog_stb && !rd_stb |=> $stable(read_snapshot_latch);
   endproperty
   a_first_latch_wins: assert property (p_first_latch_wins) // RULE15
      else $error("second count latch overwrote snapshot");

   property p_prog_clears_ptrs;
      @(posedge clk_sys) disable iff (!rst_b)
      prog_stb |=> !snap_q && !wr_hi_q && !rd_hi_q;
   endproperty
   a_prog_clears_ptrs: assert property (p_prog_clears_ptrs) // RULE27
      else $error("programming left a pointer or snapshot set");

   property p_one_byte_zero;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_stb && !prog_stb && fmt == PIT_FMT_LOW |=> load_q && preset_q[15:8] == PIT_BYTE_ZERO;
   endproperty
   a_one_byte_zero: assert property (p_one_byte_zero) // RULE24
      else $error("low-only count did not clear the high byte");

   property p_status_read;
      @(posedge clk_sys) disable iff (!rst_b)
      rd_stb && stat_held_q |=> !stat_held_q && $stable(snap_q);
   endproperty
   a_status_read: assert property (p_status_read) // RULE26
      else $error("status read did not come before the count");

   property p_null_set;
      @(posedge clk_sys) disable iff (!rst_b)
      prog_stb || load_q |=> null_q;
   endproperty
   a_null_set: assert property (p_null_set) // RULE19
      else $error("null count not raised");
endmodule

// ---- core/pit_access.sv ----
// Host access logic of a three-counter interval timer: command decode, count writes, latches and reads.
// Operation
// [RULE1] State undefined at power-up; program before use.
// [RULE2] Address 11 write captured as command byte.
// [RULE3] Bits 7:6 pick counter; 11 is read-back.
// [RULE4] Bits 5:4 pick latch, low, high, both.
// [RULE5] Bits 3:1 pick mode; bit 3 ignored.
// [RULE6] Bit 0 picks binary or four-decade decimal.
// [RULE7] Host writes command before count, matching format.
// [RULE8] Count bytes accepted at counter's own address.
// [RULE9] Interleaving across counters tracked independently.
// [RULE10] New count leaves programmed mode unchanged.
// [RULE11] Host avoids interleaved two-byte writes per counter.
// [RULE12] Unlatched direct read needs clock inhibited.
// [RULE13] Format 00 with valid pick: latch command.
// [RULE14] Latch freezes count until read or reprogram.
// [RULE15] Repeat latch before read is ignored.
// [RULE16] Reads follow byte format; others may interleave.
// [RULE17] Read and write pointers tracked separately.
// [RULE18] Host avoids interleaved two-byte reads per counter.
// [RULE19] Read-back gives count, mode, output, null flag.
// [RULE20] Read-back bits 3,2,1 pick counters 2,1,0.
// [RULE21] Read-back bit5 low latches count, bit4 status.
// [RULE22] Host writes read-back bit 0 as zero.
// [RULE23] Strobes ignored unless chip select low.
// [RULE24] Holding register loads whole; unused byte zero.
// [RULE25] Status: output, null flag, programmed bits.
// [RULE26] Status read first, then latched count.
// [RULE27] Byte pointers reset on programming, toggle.
// [RULE28] Updates land atomically in the clock domain.
module pit_access
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // Host bus, one clk_sys-wide strobe per access
   input  wire logic                 cs_b,
   input  wire logic                 rd_b,
   input  wire logic                 wr_b,
   input  wire logic                 port_sel_hi,
   input  wire logic                 port_sel_lo,
   input  wire logic [7:0]           data_in,
   output logic [7:0]                data_out,
   output logic                      data_oe,
   // Counting elements
   input  wire logic [47:0]          ce_count,
   input  wire logic [2:0]           ce_out,
   input  wire logic [2:0]           ce_loaded,
   output logic [47:0]               preset_holding_reg,
   output logic [2:0]                preset_load,
   output logic [17:0]               mode_word,
   output logic [2:0]                null_count
);
   import pit_pkg::*;

   logic [1:0]  addr;
   logic        wr_go;
   logic        rd_go;
   logic        rd_go_q;
   logic [7:0]  command_word;
   logic [1:0]  pick;
   logic [2:0]  rb_pick;
   logic [2:0]  prog_stb;
   logic [2:0]  cnt_latch;
   logic [2:0]  stat_latch;
   logic [2:0]  wr_stb;
   logic [2:0]  rd_stb;
   logic [23:0] rd_bytes;
   logic [2:0]  snap_held;
   logic [7:0]  data_q;

   assign addr         = {port_sel_hi, port_sel_lo};
   assign wr_go        = !cs_b && !wr_b && rd_b; // RULE23
   assign rd_go        = !cs_b && !rd_b && wr_b; // RULE23
   assign command_word = data_in;
   assign pick         = command_word[PIT_PICK_HI_POS:PIT_PICK_LO_POS];
   assign rb_pick      = command_word[PIT_OP_HI_POS:PIT_OP_LO_POS]; // RULE20

   ////////////////////////////////////////////////////////////////////////////
   // Command decode is fully combinational so each stroke acts in one edge; per-counter state
   // updates on that same clk_sys edge, except null count after a count write, which follows load one edge later.
   always_comb
   begin
      prog_stb   = 3'h0;
      cnt_latch  = 3'h0;
      stat_latch = 3'h0;
      wr_stb     = 3'h0;
      rd_stb     = 3'h0;
      for (int i = 0; i < PIT_UNITS; i++)
      begin
         if (wr_go && addr == PIT_ADDR_CMD) // RULE2
         begin
            if (pick == PIT_PICK_READBACK) // RULE3
            begin
               cnt_latch[i]  = rb_pick[i] && !command_word[PIT_RB_COUNT_POS]; // RULE21
               stat_latch[i] = rb_pick[i] && !command_word[PIT_RB_STAT_POS]; // RULE21
            end
            else if (pick == 2'(i))
            begin
               if (command_word[PIT_FMT_HI_POS:PIT_FMT_LO_POS] == PIT_FMT_LATCH)
                  cnt_latch[i] = 1'b1; // RULE13
               else
                  prog_stb[i] = 1'b1; // RULE4
            end
         end
         wr_stb[i] = wr_go && addr == 2'(i); // RULE9
         rd_stb[i] = rd_go && addr == 2'(i);
      end
   end

   for (genvar g = 0; g < PIT_UNITS; g++)
   begin : g_unit
      logic [5:0] pw;
      // Bit 3 does not matter for modes 2 and 3, so it is stored as written for status read-back.
      assign pw = command_word[PIT_FMT_HI_POS:PIT_BCD_POS]; // RULE5 RULE6
      pit_unit u_unit
      (
         .clk_sys            (clk_sys),
         .rst_b              (rst_b),
         .prog_stb           (prog_stb[g]),
         .prog_word          (pw),
         .cnt_latch_stb      (cnt_latch[g]),
         .stat_latch_stb     (stat_latch[g]),
         .wr_stb             (wr_stb[g]),
         .rd_stb             (rd_stb[g]),
         .wr_data            (data_in),
         .ce_count           (ce_count[16*g +: 16]),
         .ce_out             (ce_out[g]),
         .ce_loaded          (ce_loaded[g]),
         .rd_byte            (rd_bytes[8*g +: 8]),
         .mode_word          (mode_word[6*g +: 6]), // RULE10 RULE19
         .preset_holding_reg (preset_holding_reg[16*g +: 16]), // RULE28
         .preset_load        (preset_load[g]),
         .null_count         (null_count[g]),
         .snap_held          (snap_held[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data is registered; the bus sees it one edge after the read stroke.
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         data_q  <= PIT_BYTE_ZERO;
         rd_go_q <= 1'b0;
      end
      else
      begin
         rd_go_q <= rd_go && addr != PIT_ADDR_CMD;
         if (rd_go && addr != PIT_ADDR_CMD)
            data_q <= rd_bytes[8*addr +: 8];
      end
   end

   assign data_out = data_q;
   assign data_oe  = rd_go_q;

   property p_latch_sets_hold;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_go && addr == PIT_ADDR_CMD && pick == PIT_ADDR_UNIT0
         && data_in[PIT_FMT_HI_POS:PIT_FMT_LO_POS] == PIT_FMT_LATCH |=> snap_held[0];
   endproperty
   a_latch_sets_hold: assert property (p_latch_sets_hold) // RULE14
      else $error("latch command did not hold counter 0");

   property p_cs_gates;
      @(posedge clk_sys) disable iff (!rst_b)
      cs_b |=> !data_oe;
   endproperty
   a_cs_gates: assert property (p_cs_gates) // RULE23
      else $error("read answered without chip select");

   property p_readback_pick;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_go && addr == PIT_ADDR_CMD && pick == PIT_PICK_READBACK && !data_in[PIT_RB_COUNT_POS]
         && data_in[PIT_OP_HI_POS] |=> snap_held[2];
   endproperty
   a_readback_pick: assert property (p_readback_pick) // RULE20
      else $error("read-back did not latch counter 2");

   property p_mode_kept;
      @(posedge clk_sys) disable iff (!rst_b)
      wr_stb[1] && !prog_stb[1] |=> $stable(mode_word[11:6]);
   endproperty
   a_mode_kept: assert property (p_mode_kept) // RULE10
      else $error("count write changed mode");

   property p_read_answer;
      @(posedge clk_sys) disable iff (!rst_b)
      rd_go && addr != PIT_ADDR_CMD |=> data_oe;
   endproperty
   a_read_answer: assert property (p_read_answer) // RULE16
      else $error("counter read was not answered");
endmodule

// ---- verification/pit_host_model.sv ----
// Host bus model that issues one-cycle access strokes on the timer's peripheral port.
module pit_host_model
(
   // Clock
   input  wire logic       clk_sys,
   // Host bus
   output logic            cs_b,
   output logic            rd_b,
   output logic            wr_b,
   output logic            port_sel_hi,
   output logic            port_sel_lo,
   output logic [7:0]      data_in
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      {cs_b, rd_b, wr_b} = 3'h7;
      {port_sel_hi, port_sel_lo} = 2'h0;
      data_in = 8'h00;
   end

   // The bus is released one edge later; data then flips so a stale byte is never mistaken for a new one.
   task automatic stroke(input logic sel, input logic wr, input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      cs_b = ~sel;
      wr_b = ~wr;
      rd_b = wr;
      {port_sel_hi, port_sel_lo} = a;
      data_in = d;
      @(posedge clk_sys);
      #1;
      {cs_b, rd_b, wr_b} = 3'h7;
      data_in = ~d;
   endtask
endmodule

// ---- verification/test_pit_access.sv ----
// Self-checking bench for the interval timer host access logic.
module test_pit_access;
   timeunit 1ns;
   timeprecision 100ps;
   import pit_pkg::*;

   logic        clk_sys, rst_b, cs_b, rd_b, wr_b, port_sel_hi, port_sel_lo, data_oe;
   logic [7:0]  data_in, data_out;
   logic [47:0] ce_count, preset_holding_reg, lat;
   logic [2:0]  ce_out, ce_loaded, preset_load, null_count;
   logic [17:0] mode_word;
   logic [7:0]  rd_q[$];
   logic [17:0] ld_q[$];
   logic [5:0]  mw[3];
   logic [31:0] seed = 32'h00007B33;
   int          miscompares = 0;
   int          n_tests = 0;

   pit_access uut (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
      .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .ce_count(ce_count), .ce_out(ce_out), .ce_loaded(ce_loaded),
      .preset_holding_reg(preset_holding_reg), .preset_load(preset_load), .mode_word(mode_word),
      .null_count(null_count));
   pit_host_model host (.clk_sys(clk_sys), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
      .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .data_in(data_in));

   ////////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      host.stroke(1'b1, 1'b1, a, d);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      host.stroke(1'b1, 1'b0, a, 8'h00);
   endtask

   task automatic prog(input int g, input logic [7:0] w);
      mw[g] = w[5:0];
      wr(PIT_ADDR_CMD, {2'(g), w[5:0]});
      check("mode", mode_word[6*g+:6], w[5:0]);
      check("null", null_count[g], 1'b1);
   endtask

   task automatic cnt(input int g, input logic [15:0] v);
      logic [1:0] f;
      f = mw[g][5:4];
      ld_q.push_back({2'(g), f == PIT_FMT_LOW ? {8'h00, v[7:0]} : f == PIT_FMT_HIGH ? {v[15:8], 8'h00} : v});
      if (f != PIT_FMT_HIGH)
         wr(2'(g), v[7:0]);
      if (f != PIT_FMT_LOW)
         wr(2'(g), v[15:8]);
   endtask

   task automatic rdcnt(input int g, input logic [15:0] v);
      if (mw[g][5:4] != PIT_FMT_HIGH)
         rd(2'(g), v[7:0]);
      if (mw[g][5:4] != PIT_FMT_LOW)
         rd(2'(g), v[15:8]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // A completed load is handed to the counting element one cycle later, which clears null count.
   always @(posedge clk_sys)
   begin
      ce_loaded <= preset_load;
      if (data_oe === 1'b1)
      begin
         if (rd_q.size() == 0)
            check("stray read", 18'h1, 18'h0);
         else
            check("read byte", data_out, rd_q.pop_front());
      end
      for (int g = 0; g < 3; g++)
         if (preset_load[g] === 1'b1)
            check("load", {2'(g), preset_holding_reg[16*g+:16]}, ld_q.size() ? ld_q.pop_front() : 18'h3FFFF);
   end

   initial
   begin
      #60000;
      miscompares++;
      results();
   end

   initial
   begin
      logic [15:0] v;
      rst_b = 1'b0;
      ce_count = 48'h0;
      ce_out = 3'h0;
      ce_loaded = 3'h0;
      repeat (5) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      check("reset mode", mode_word, {3{PIT_MODE_RESET}});
      check("reset null", null_count, 3'h7);
      for (int i = 0; i < 6; i++)
      begin
         prog(i % 3, {2'h0, 2'((i + i / 3) % 3 + 1), 3'(i), 1'(i)});
         cnt(i % 3, 16'(xs()));
         check("mode kept", mode_word[6*(i%3)+:6], mw[i%3]);
      end
      // Latch, change the count, latch again, read with another counter programmed in between.
      prog(0, 8'h34);
      v = 16'(xs());
      ce_count[15:0] = v;
      wr(PIT_ADDR_CMD, 8'h00);
      ce_count[15:0] = ~v;
      wr(PIT_ADDR_CMD, 8'h0F);
      rd(PIT_ADDR_UNIT0, v[7:0]);
      prog(1, 8'h30);
      rd(PIT_ADDR_UNIT0, v[15:8]);
      v = ~v;
      rdcnt(0, v);
      // Reads and writes of one counter interleaved.
      wr(PIT_ADDR_CMD, 8'h00);
      ce_count[15:0] = 16'h1234;
      ld_q.push_back({2'h0, 16'hA55A});
      rd(PIT_ADDR_UNIT0, v[7:0]);
      wr(PIT_ADDR_UNIT0, 8'h5A);
      rd(PIT_ADDR_UNIT0, v[15:8]);
      wr(PIT_ADDR_UNIT0, 8'hA5);
      // Two counters' count bytes interleaved.
      prog(2, 8'h36);
      ld_q.push_back(18'h1BEEF);
      ld_q.push_back(18'h2C0DE);
      wr(PIT_ADDR_UNIT1, 8'hEF);
      wr(PIT_ADDR_UNIT2, 8'hDE);
      wr(PIT_ADDR_UNIT1, 8'hBE);
      wr(PIT_ADDR_UNIT2, 8'hC0);
      repeat (3) @(posedge clk_sys);
      #1;
      // Count and status of all counters in one command; status comes out first.
      ce_out = 3'h5;
      lat = {16'(xs()), 16'(xs()), 16'(xs())};
      ce_count = lat;
      wr(PIT_ADDR_CMD, 8'hCE);
      ce_count = ~lat;
      for (int g = 0; g < 3; g++)
      begin
         rd(2'(g), {ce_out[g], 1'b0, mw[g]});
         rdcnt(g, lat[16*g+:16]);
      end
      wr(PIT_ADDR_CMD, 8'hE4);
      rd(PIT_ADDR_UNIT1, {ce_out[1], 1'b0, mw[1]});
      rdcnt(1, ce_count[31:16]);
      wr(PIT_ADDR_CMD, 8'hD8);
      lat = ce_count;
      ce_count = ~lat;
      rdcnt(2, lat[47:32]);
      prog(0, 8'h34);
      wr(PIT_ADDR_CMD, 8'hE2);
      rd(PIT_ADDR_UNIT0, {ce_out[0], 1'b1, 6'h34});
      // Refused strokes: deselected write and read, read of the command port.
      host.stroke(1'b0, 1'b1, PIT_ADDR_CMD, 8'h10);
      check("deselected", mode_word[5:0], mw[0]);
      host.stroke(1'b0, 1'b0, PIT_ADDR_UNIT0, 8'h00);
      host.stroke(1'b1, 1'b0, PIT_ADDR_CMD, 8'h00);
      repeat (4) @(posedge clk_sys);
      check("queues", 18'(rd_q.size() + ld_q.size()), 18'h0);
      results();
   end
endmodule
